// File: cssc_consts.vh
// Constants for the clock switch and sleep control block.
// Assumes byte-wide registers, each in one 32-bit Avalon word.
`ifndef CSSC_CONSTS_VH
`define CSSC_CONSTS_VH

// Register word addresses on the Avalon slave.
`define CSSC_ADDR_CMD 2'h0
`define CSSC_ADDR_SEL 2'h1
`define CSSC_ADDR_SLEEP 2'h2

// Clock command/status register fields.
`define CSSC_CMD_UNLOCK_BIT 7
`define CSSC_CMD_STABLE_BIT 4
`define CSSC_CMD_UNLOCK_WORD 8'h80
`define CSSC_CMD_RESET 4'h0

// Clock selection register fields.
`define CSSC_SEL_PIN_BIT 6
`define CSSC_SEL_SUT_LSB 4

// Sleep control register fields.
`define CSSC_SLP_ARM_BIT 0
`define CSSC_SLP_KIND_LSB 1
`define CSSC_SLP_BUSY_BIT 7
`define CSSC_SLP_KIND_RESET 3'h0

// Command codes.
`define CSSC_CMD_NONE 4'h0
`define CSSC_CMD_DISABLE 4'h1
`define CSSC_CMD_ENABLE 4'h2
`define CSSC_CMD_AVAIL 4'h3
`define CSSC_CMD_SWITCH 4'h4
`define CSSC_CMD_RECOVER 4'h5
`define CSSC_CMD_UNDEF 4'h6
`define CSSC_CMD_CLKOUT 4'h7

// Sleep kinds.
`define CSSC_KIND_IDLE 3'h0
`define CSSC_KIND_ADCNR 3'h1
`define CSSC_KIND_PDOWN 3'h2
`define CSSC_KIND_STANDBY 3'h6

// Timing counts in core clock cycles.
`define CSSC_UNLOCK_CYC 3'h4
`define CSSC_WAKE_EXTRA_CYC 12'h004
`define CSSC_STANDBY_CYC 12'h006
`define CSSC_SUT0_CYC 12'h010
`define CSSC_SUT1_CYC 12'h040
`define CSSC_SUT2_CYC 12'h100
`define CSSC_SUT3_CYC 12'h400

`endif

// File: cssc_unlock.v
// Four-cycle unlock window for the clock command register.
// Assumes set and close requests are one-cycle pulses from the bus logic.
`timescale 1ns/1ps
`include "cssc_consts.vh"

module cssc_unlock (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Requests
    input wire set_req,
    input wire close_req,
    // Window state
    output reg open
);

reg [2:0] count;

always @(posedge core_clk) begin
    if (srst) begin
        open <= 1'b0;
        count <= 3'h0;
    end else if (open) begin
        // (R2) early close on command
        if (close_req || count == `CSSC_UNLOCK_CYC - 3'h1) begin
            open <= 1'b0;
        end
        // (R3) rewrite does not restart
        count <= count + 3'h1;
    end else if (set_req) begin
        open <= 1'b1;
        count <= 3'h0;
    end
end

endmodule // cssc_unlock

// File: cssc_wake_timer.v
// Down-counter that times the stall between a wake event and resumption.
// Assumes start is a one-cycle pulse and load is at least two.
// Done rises one cycle before the count runs out, so that the resume pulse
// registered from it lands exactly load cycles after start.
`timescale 1ns/1ps

module cssc_wake_timer (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Start
    input wire start,
    input wire [11:0] load,
    // Status
    output reg busy,
    output reg done
);

reg [11:0] remain;

always @(posedge core_clk) begin
    if (srst) begin
        busy <= 1'b0;
        done <= 1'b0;
        remain <= 12'h000;
    end else if (start) begin
        busy <= 1'b1;
        done <= 1'b0;
        remain <= load;
    end else if (busy) begin
        remain <= remain - 12'h001;
        if (remain == 12'h002) begin
            busy <= 1'b0;
            done <= 1'b1;
        end else begin
            done <= 1'b0;
        end
    end else begin
        done <= 1'b0;
    end
end

endmodule // cssc_wake_timer

// File: cssc_top.v
// Clock command unlock, clock switch command issue and sleep-mode clock gating.
// Assumes synchronous inputs, one-cycle pulses on halt and confirm, and
// that watchdog, brown-out and external resets all arrive on srst.
//
// What this block and its software do
// (R1) Unlock sets only when other bits are zero.
// (R2) Unlock clears after four cycles or command.
// (R3) Rewriting unlock neither restarts nor clears window.
// (R4) Reserved bits read back as zero.
// (R5) Availability request clears the stable flag.
// (R6) Stable flag sets on availability confirmation only.
// (R7) Command field decodes to the listed commands.
// (R8) Software writes unlock, then command within four.
// (R9) Software keeps interrupts off during the sequence.
// (R10) Pin select from fuse, used by output command.
// (R11) Startup code from fuse, feeds enable/disable.
// (R12) Source code from fuse, feeds four commands.
// (R13) Recover loads the currently driving source code.
// (R14) Sleep needs arm bit plus halt; kind selects.
// (R15) Interrupt wake stalls four beyond startup, then resumes.
// (R16) State kept in sleep; reset wakes to vector.
// (R17) Idle stops only core and program-memory clocks.
// (R18) Idle wakes on external and internal interrupts.
// (R19) Noise reduction also stops the peripheral clock.
// (R20) Noise reduction wakes on listed sources only.
// (R21) Power-down halts all clocks; few wake sources.
// (R22) Standby keeps oscillator, wakes in six cycles.
// (R23) Reserved sleep kinds enter no sleep.
// (R24) Command writes while locked are ignored.
// (R25) Undefined command 0110 does nothing.
`timescale 1ns/1ps
`include "cssc_consts.vh"

module cssc_top (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Avalon-MM slave
    input wire [1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Fuses sampled during reset
    input wire [3:0] source_fuse,
    input wire [1:0] startup_fuse,
    input wire clkout_fuse,
    // Clock switch command port
    output reg switch_cmd_valid,
    output reg [3:0] switch_cmd_code,
    output reg [3:0] switch_cmd_source,
    output reg [1:0] switch_cmd_startup,
    output reg switch_cmd_pin_select,
    input wire avail_confirm,
    input wire [3:0] current_source,
    // Core and wake events
    input wire halt_exec,
    input wire wake_ext_irq,
    input wire wake_int_irq,
    input wire wake_adc_done,
    input wire wake_timer_irq,
    input wire wake_mem_ready,
    input wire wake_ext_level,
    input wire wake_pwm_unit_irq,
    // Clock domain gating and status
    output reg core_clock_domain_en,
    output reg program_memory_clock_domain_en,
    output reg peripheral_clock_domain_en,
    output reg generated_clock_en,
    output reg oscillator_en,
    output reg wake_resume,
    output reg sleeping
);

localparam ST_RUN = 3'b001;
localparam ST_SLEEP = 3'b010;
localparam ST_WAKE = 3'b100;

// (R7) command decode
function cmd_is_active;
    input [3:0] code;
    begin
        case (code)
            `CSSC_CMD_DISABLE, `CSSC_CMD_ENABLE, `CSSC_CMD_AVAIL,
            `CSSC_CMD_SWITCH, `CSSC_CMD_RECOVER, `CSSC_CMD_CLKOUT: cmd_is_active = 1'b1;
            default: cmd_is_active = 1'b0;
        endcase
    end
endfunction

// (R23) reserved kinds rejected
function kind_defined;
    input [2:0] kind;
    begin
        case (kind)
            `CSSC_KIND_IDLE, `CSSC_KIND_ADCNR,
            `CSSC_KIND_PDOWN, `CSSC_KIND_STANDBY: kind_defined = 1'b1;
            default: kind_defined = 1'b0;
        endcase
    end
endfunction

function [11:0] sut_cycles;
    input [1:0] code;
    begin
        case (code)
            2'h0: sut_cycles = `CSSC_SUT0_CYC;
            2'h1: sut_cycles = `CSSC_SUT1_CYC;
            2'h2: sut_cycles = `CSSC_SUT2_CYC;
            default: sut_cycles = `CSSC_SUT3_CYC;
        endcase
    end
endfunction

// Bus handshake: every access is answered on the second cycle.
wire bus_req = avs_read | avs_write;
wire bus_done = bus_req & ~avs_waitrequest;

always @(posedge core_clk) begin
    if (srst) begin
        avs_waitrequest <= 1'b1;
    end else if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
    end else begin
        avs_waitrequest <= 1'b1;
    end
end

wire [7:0] wbyte = avs_writedata[7:0];
wire wr_lane = bus_done & avs_write & avs_byteenable[0];
wire wr_cmd = wr_lane && avs_address == `CSSC_ADDR_CMD;
wire wr_sel = wr_lane && avs_address == `CSSC_ADDR_SEL;
wire wr_sleep = wr_lane && avs_address == `CSSC_ADDR_SLEEP;

// Register state
reg [3:0] cmd_field;
reg source_stable_flag;
reg clock_pin_drive_select;
reg [1:0] startup_time_code;
reg [3:0] source_select_code;
reg sleep_arm;
reg [2:0] sleep_kind;
wire clock_cmd_unlock;

// (R1) unlock only with other bits zero
wire unlock_set = wr_cmd && wbyte == `CSSC_CMD_UNLOCK_WORD;
// (R24) command only inside window
wire cmd_write = wr_cmd && !wbyte[`CSSC_CMD_UNLOCK_BIT] && clock_cmd_unlock;
// (R25) undefined and 1xxx issue nothing
wire cmd_issue = cmd_write && cmd_is_active(wbyte[3:0]);

cssc_unlock u_unlock (
    .core_clk(core_clk),
    .srst(srst),
    .set_req(unlock_set),
    .close_req(cmd_write),
    .open(clock_cmd_unlock)
);

always @(posedge core_clk) begin
    if (srst) begin
        cmd_field <= `CSSC_CMD_RESET;
    end else if (cmd_write) begin
        cmd_field <= wbyte[3:0];
    end
end

always @(posedge core_clk) begin
    if (srst) begin
        source_stable_flag <= 1'b0;
    end else if (avail_confirm) begin
        // (R6) set on confirmation, wins over clear
        source_stable_flag <= 1'b1;
    end else if (cmd_issue && wbyte[3:0] == `CSSC_CMD_AVAIL) begin
        // (R5) cleared on request
        source_stable_flag <= 1'b0;
    end
end

// Selection fields reload from fuses while reset is held.
always @(posedge core_clk) begin
    if (srst) begin
        // (R10) (R11) (R12) fuse load
        clock_pin_drive_select <= clkout_fuse;
        startup_time_code <= startup_fuse;
        source_select_code <= source_fuse;
    end else if (cmd_issue && wbyte[3:0] == `CSSC_CMD_RECOVER) begin
        // (R13) recover driving source only
        source_select_code <= current_source;
    end else if (wr_sel) begin
        clock_pin_drive_select <= wbyte[`CSSC_SEL_PIN_BIT];
        startup_time_code <= wbyte[`CSSC_SEL_SUT_LSB +: 2];
        source_select_code <= wbyte[3:0];
    end
end

// Command port carries the selection fields current at issue time.
always @(posedge core_clk) begin
    if (srst) begin
        switch_cmd_valid <= 1'b0;
        switch_cmd_code <= `CSSC_CMD_NONE;
        switch_cmd_source <= 4'h0;
        switch_cmd_startup <= 2'h0;
        switch_cmd_pin_select <= 1'b0;
    end else begin
        // (R7) issue decoded command
        switch_cmd_valid <= cmd_issue;
        if (cmd_issue) begin
            switch_cmd_code <= wbyte[3:0];
            // (R12) source code operand
            switch_cmd_source <= source_select_code;
            // (R11) startup code operand
            switch_cmd_startup <= startup_time_code;
            // (R10) pin select operand
            switch_cmd_pin_select <= clock_pin_drive_select;
        end
    end
end

always @(posedge core_clk) begin
    if (srst) begin
        sleep_arm <= 1'b0;
        sleep_kind <= `CSSC_SLP_KIND_RESET;
    end else if (wr_sleep) begin
        sleep_arm <= wbyte[`CSSC_SLP_ARM_BIT];
        sleep_kind <= wbyte[`CSSC_SLP_KIND_LSB +: 3];
    end
end

// Read data are captured on the cycle the answer is prepared.
always @(posedge core_clk) begin
    if (srst) begin
        avs_readdata <= 32'h00000000;
    end else if (bus_req && avs_waitrequest) begin
        // (R4) reserved bits zero
        case (avs_address)
            `CSSC_ADDR_CMD: avs_readdata <= {24'h000000, clock_cmd_unlock, 2'h0,
                                             source_stable_flag, cmd_field};
            `CSSC_ADDR_SEL: avs_readdata <= {24'h000000, 1'b0, clock_pin_drive_select,
                                             startup_time_code, source_select_code};
            `CSSC_ADDR_SLEEP: avs_readdata <= {24'h000000, sleeping, 3'h0,
                                               sleep_kind, sleep_arm};
            default: avs_readdata <= 32'h00000000;
        endcase
    end
end

// Sleep sequencing
reg [2:0] state;
reg [2:0] next_state;
reg [2:0] mode;
reg [11:0] next_wake_load;
reg wake_hit;
wire wake_busy;
wire wake_done;

always @* begin
    case (mode)
        // (R18) idle wakes on any interrupt
        `CSSC_KIND_IDLE: wake_hit = wake_ext_irq | wake_int_irq | wake_adc_done |
                                    wake_timer_irq | wake_mem_ready | wake_ext_level |
                                    wake_pwm_unit_irq;
        // (R20) noise reduction wake set
        `CSSC_KIND_ADCNR: wake_hit = wake_adc_done | wake_timer_irq | wake_mem_ready |
                                     wake_ext_level;
        // (R21) (R22) deep modes wake set
        default: wake_hit = wake_pwm_unit_irq | wake_ext_level;
    endcase
end

always @* begin
    case (mode)
        // (R22) standby six-cycle wake
        `CSSC_KIND_STANDBY: next_wake_load = `CSSC_STANDBY_CYC;
        // (R15) startup plus four
        `CSSC_KIND_PDOWN: next_wake_load = sut_cycles(startup_time_code) +
                                           `CSSC_WAKE_EXTRA_CYC;
        default: next_wake_load = `CSSC_WAKE_EXTRA_CYC;
    endcase
end

always @* begin
    case (state)
        ST_RUN: begin
            // (R14) (R23) armed halt with valid kind
            if (halt_exec && sleep_arm && kind_defined(sleep_kind)) begin
                next_state = ST_SLEEP;
            end else begin
                next_state = ST_RUN;
            end
        end
        ST_SLEEP: next_state = wake_hit ? ST_WAKE : ST_SLEEP;
        ST_WAKE: next_state = wake_done ? ST_RUN : ST_WAKE;
        default: next_state = ST_RUN;
    endcase
end

cssc_wake_timer u_wake (
    .core_clk(core_clk),
    .srst(srst),
    .start(state == ST_SLEEP && wake_hit),
    .load(next_wake_load),
    .busy(wake_busy),
    .done(wake_done)
);

// A reset in any state returns to run; register contents outside this
// block are not touched, so memory keeps its value across sleep.
always @(posedge core_clk) begin
    if (srst) begin
        // (R16) reset wakes the device
        state <= ST_RUN;
        mode <= `CSSC_KIND_IDLE;
    end else begin
        state <= next_state;
        if (state == ST_RUN && next_state == ST_SLEEP) begin
            mode <= sleep_kind;
        end
    end
end

always @(posedge core_clk) begin
    if (srst) begin
        core_clock_domain_en <= 1'b1;
        program_memory_clock_domain_en <= 1'b1;
        peripheral_clock_domain_en <= 1'b1;
        generated_clock_en <= 1'b1;
        oscillator_en <= 1'b1;
        wake_resume <= 1'b0;
        sleeping <= 1'b0;
    end else begin
        wake_resume <= state == ST_WAKE && wake_done;
        sleeping <= next_state != ST_RUN;
        case (next_state)
            ST_SLEEP: begin
                // (R17) core and program memory stop
                core_clock_domain_en <= 1'b0;
                program_memory_clock_domain_en <= 1'b0;
                // (R19) peripheral clock also stops
                peripheral_clock_domain_en <= sleep_kind == `CSSC_KIND_IDLE ||
                                              mode == `CSSC_KIND_IDLE && state == ST_SLEEP;
                // (R21) deep modes halt generated clocks
                generated_clock_en <= (state == ST_SLEEP) ?
                                      (mode == `CSSC_KIND_IDLE || mode == `CSSC_KIND_ADCNR) :
                                      (sleep_kind == `CSSC_KIND_IDLE ||
                                       sleep_kind == `CSSC_KIND_ADCNR);
                // (R22) standby keeps oscillator
                oscillator_en <= (state == ST_SLEEP) ? (mode != `CSSC_KIND_PDOWN) :
                                 (sleep_kind != `CSSC_KIND_PDOWN);
            end
            ST_WAKE: begin
                // (R15) core stays stalled during wake
                core_clock_domain_en <= 1'b0;
                program_memory_clock_domain_en <= 1'b0;
                peripheral_clock_domain_en <= 1'b1;
                generated_clock_en <= 1'b1;
                oscillator_en <= 1'b1;
            end
            default: begin
                core_clock_domain_en <= 1'b1;
                program_memory_clock_domain_en <= 1'b1;
                peripheral_clock_domain_en <= 1'b1;
                generated_clock_en <= 1'b1;
                oscillator_en <= 1'b1;
            end
        endcase
    end
end

endmodule // cssc_top

// File: cssc_top_sva.sv
// Checker for cssc_top: bus timing, command pulses and clock gating.
// Sees only top-level ports; attached by the bind below the module.
`timescale 1ns/1ps

module cssc_top_chk (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Avalon-MM slave
    input wire [1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Command port and gating
    input wire switch_cmd_valid,
    input wire [3:0] switch_cmd_code,
    input wire core_clock_domain_en,
    input wire peripheral_clock_domain_en,
    input wire generated_clock_en,
    input wire oscillator_en,
    input wire halt_exec,
    input wire wake_resume,
    input wire sleeping
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest not low one cycle");

    property p_rd_zero;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0
            && (avs_address != 2'h0 || avs_readdata[6:5] == 2'h0)
            && (avs_address != 2'h1 || !avs_readdata[7])
            && (avs_address != 2'h3 || avs_readdata == 32'h0);
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("reserved bits read nonzero");

    property p_cmd_cause;
        switch_cmd_valid |-> $past(avs_write && !avs_waitrequest && avs_address == 2'h0)
            && switch_cmd_code == $past(avs_writedata[3:0]);
    endproperty
    a_cmd_cause: assert property (p_cmd_cause) else $error("command without write");

    property p_cmd_code;
        switch_cmd_valid |-> switch_cmd_code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
    endproperty
    a_cmd_code: assert property (p_cmd_code) else $error("undefined code issued");

    property p_sleep_cause;
        $rose(sleeping) |-> $past(halt_exec);
    endproperty
    a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without halt");

    property p_io_gate;
        !peripheral_clock_domain_en |-> sleeping && !core_clock_domain_en;
    endproperty
    a_io_gate: assert property (p_io_gate) else $error("peripheral clock gated awake");

    property p_osc_gate;
        !oscillator_en |-> sleeping && !generated_clock_en;
    endproperty
    a_osc_gate: assert property (p_osc_gate) else $error("oscillator off, clocks on");

    property p_resume;
        wake_resume |-> $past(sleeping) && !sleeping && core_clock_domain_en ##1 !wake_resume;
    endproperty
    a_resume: assert property (p_resume) else $error("bad resume pulse");

    property p_resume_end;
        $fell(sleeping) |-> wake_resume;
    endproperty
    a_resume_end: assert property (p_resume_end) else $error("sleep ended without resume");
endmodule // cssc_top_chk

bind cssc_top cssc_top_chk i_chk (.core_clk(core_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .switch_cmd_valid(switch_cmd_valid),
    .switch_cmd_code(switch_cmd_code), .core_clock_domain_en(core_clock_domain_en),
    .peripheral_clock_domain_en(peripheral_clock_domain_en),
    .generated_clock_en(generated_clock_en), .oscillator_en(oscillator_en),
    .halt_exec(halt_exec), .wake_resume(wake_resume), .sleeping(sleeping));

// File: cssc_top_bench.sv
// Self-checking bench for cssc_top: bus access, command unlock, sleep and wake.
// All inputs change at the rising edge; bus answers are taken at the rising
// edge that sees waitrequest low, other outputs are sampled on the falling edge.
`timescale 1ns/1ps
`include "cssc_consts.vh"

module cssc_top_bench;
    reg core_clk = 1'b0;
    reg srst = 1'b1;
    reg [1:0] avs_address = 2'h0;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg [3:0] avs_byteenable = 4'hf;
    reg [3:0] sfuse = 4'ha;
    reg [1:0] tfuse = 2'h2;
    reg ofuse = 1'b1;
    reg confirm = 1'b0;
    reg halt = 1'b0;
    reg [6:0] wk = 7'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, cv, cp, wake_resume, sleeping;
    wire [3:0] cc, cs;
    wire [1:0] ct;
    wire [4:0] en;
    integer miscompares = 0;
    integer tests_run = 0;
    integer pulses = 0;
    integer i, n, p0;
    reg [31:0] rdata;
    reg [10:0] last, m;
    reg [24:0] r;
    // Command rows: code, then whether a command pulse is expected.
    reg [4:0] rows [0:10] = '{5'h00, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0c, 5'h0f, 5'h10,
        5'h18, 5'h1e, 5'h0b};
    // Sleep rows: kind, waking input, non-waking inputs, expected stall (0 = no sleep).
    reg [24:0] srow [0:8] = '{25'h0080004, 25'h0000004, 25'h0502004, 25'h0a9e104,
        25'h1b1e006, 25'h0c00000, 25'h1000000, 25'h1400000, 25'h1c00000};

    cssc_top i_dut (
        .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .source_fuse(sfuse),
        .startup_fuse(tfuse), .clkout_fuse(ofuse), .switch_cmd_valid(cv),
        .switch_cmd_code(cc), .switch_cmd_source(cs), .switch_cmd_startup(ct),
        .switch_cmd_pin_select(cp), .avail_confirm(confirm), .current_source(4'h3),
        .halt_exec(halt), .wake_ext_irq(wk[0]), .wake_int_irq(wk[1]), .wake_adc_done(wk[2]),
        .wake_timer_irq(wk[3]), .wake_mem_ready(wk[4]), .wake_ext_level(wk[5]),
        .wake_pwm_unit_irq(wk[6]), .core_clock_domain_en(en[4]),
        .program_memory_clock_domain_en(en[3]), .peripheral_clock_domain_en(en[2]),
        .generated_clock_en(en[1]), .oscillator_en(en[0]), .wake_resume(wake_resume),
        .sleeping(sleeping)
    );

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    always @(negedge core_clk) begin
        if (cv === 1'b1) begin
            pulses = pulses + 1;
            last = {cc, cs, ct, cp};
        end
    end

    task wrap_up;
        begin
            $display("compares %0d, mismatches %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // With keep set the strobe stays up so the next access follows at once.
    task bus(input logic w, input logic [1:0] a, input logic [7:0] d, input logic keep);
        begin
            avs_write <= w;
            avs_read <= !w;
            avs_address <= a;
            avs_writedata <= {24'h0, d};
            n = 0;
            do begin
                @(posedge core_clk);
                n = n + 1;
            end while (avs_waitrequest !== 1'b0 && n < 20);
            rdata = avs_readdata;
            if (avs_waitrequest !== 1'b0) begin
                chk({31'h0, avs_waitrequest}, 32'h0);
            end
            if (!keep) begin
                avs_write <= 1'b0;
                avs_read <= 1'b0;
                @(posedge core_clk);
            end
        end
    endtask

    task gap(input logic f, input integer k, input integer e);
        begin
            p0 = pulses;
            bus(1'b1, 2'h0, 8'h80, 1'b1);
            repeat (k) bus(f, {1'b0, !f}, 8'h80, 1'b1);
            bus(1'b1, 2'h0, 8'h02, 1'b0);
            chk(pulses, p0 + e);
        end
    endtask

    task hop;
        begin
            halt <= 1'b1;
            @(posedge core_clk);
            halt <= 1'b0;
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
        end
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        bus(1'b0, `CSSC_ADDR_SEL, 8'h0, 1'b0);
        chk(rdata, 32'h6a);
        bus(1'b1, 2'h3, 8'hff, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            if (i != 1) begin
                bus(1'b0, i[1:0], 8'h0, 1'b0);
                chk(rdata, 32'h0);
            end
        end
        avs_byteenable <= 4'h0;
        bus(1'b1, `CSSC_ADDR_SEL, 8'h00, 1'b1);
        bus(1'b1, `CSSC_ADDR_CMD, 8'h80, 1'b1);
        bus(1'b1, `CSSC_ADDR_CMD, 8'h02, 1'b0);
        avs_byteenable <= 4'hf;
        bus(1'b0, `CSSC_ADDR_SEL, 8'h0, 1'b0);
        chk(rdata, 32'h6a);
        confirm <= 1'b1;
        @(posedge core_clk);
        confirm <= 1'b0;
        bus(1'b0, `CSSC_ADDR_CMD, 8'h0, 1'b0);
        chk(rdata, 32'h10);
        // decode table; unlock then command, wake inputs quiet
        for (i = 0; i < 11; i = i + 1) begin
            p0 = pulses;
            bus(1'b1, `CSSC_ADDR_CMD, 8'h80, 1'b1);
            bus(1'b1, `CSSC_ADDR_CMD, {4'h0, rows[i][4:1]}, 1'b0);
            bus(1'b1, `CSSC_ADDR_CMD, {4'h0, rows[i][4:1]}, 1'b0);
            chk(pulses, p0 + rows[i][0]);
            m = {4'hf, (rows[i][4:1] inside {4'h1, 4'h2, 4'h3, 4'h4}) ? 4'hf : 4'h0,
                (rows[i][4:1] inside {4'h1, 4'h2}) ? 2'h3 : 2'h0, rows[i][4:1] == 4'h7};
            if (rows[i][0]) chk(last & m, {rows[i][4:1], 7'h55} & m);
            if (rows[i][4:1] == 4'h3) begin
                bus(1'b0, `CSSC_ADDR_CMD, 8'h0, 1'b0);
                chk(rdata & 32'h10, 32'h0);
            end
        end
        bus(1'b0, `CSSC_ADDR_SEL, 8'h0, 1'b0);
        chk(rdata, 32'h63);
        p0 = pulses;
        bus(1'b1, `CSSC_ADDR_CMD, 8'h81, 1'b1);
        bus(1'b1, `CSSC_ADDR_CMD, 8'h02, 1'b0);
        chk(pulses, p0);
        gap(1'b0, 1, 1);
        gap(1'b0, 2, 0);
        gap(1'b1, 1, 1);
        gap(1'b1, 2, 0);
        bus(1'b1, `CSSC_ADDR_SLEEP, 8'h00, 1'b0);
        hop;
        chk(sleeping, 1'b0);
        for (i = 0; i < 9; i = i + 1) begin
            r = srow[i];
            @(posedge core_clk);
            bus(1'b1, `CSSC_ADDR_SLEEP, {4'h0, r[24:22], 1'b1}, 1'b0);
            wk <= r[18:12];
            hop;
            chk(sleeping, r[11:0] != 12'h0);
            chk(en, r[11:0] == 12'h0 ? 5'h1f : {2'h0, r[24:22] == 3'h0, r[24:22] < 3'h2,
                r[24:22] != 3'h2});
            if (r[11:0] != 12'h0) begin
                @(posedge core_clk);
                wk <= r[18:12] | (7'h1 << r[21:19]);
                n = 0;
                do begin
                    @(negedge core_clk);
                    n = n + 1;
                end while (wake_resume !== 1'b1 && n < 2000);
                chk(n, r[11:0] + 2);
            end
            @(posedge core_clk);
            wk <= 7'h0;
        end
        bus(1'b1, `CSSC_ADDR_SLEEP, 8'h01, 1'b0);
        hop;
        @(posedge core_clk);
        srst <= 1'b1;
        sfuse <= 4'h5;
        tfuse <= 2'h1;
        ofuse <= 1'b0;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        chk({sleeping, en}, 6'h1f);
        @(posedge core_clk);
        bus(1'b0, `CSSC_ADDR_SEL, 8'h0, 1'b0);
        chk(rdata, 32'h15);
        wrap_up;
    end

    initial begin
        #100000;
        miscompares = miscompares + 1;
        wrap_up;
    end
endmodule // cssc_top_bench
